// ===== core/fpw_pkg.sv
// package with register map, field layout and reset values of the pull word block
package fpw_pkg;
  localparam int unsigned ADDR_W      = 8;
  localparam int unsigned DATA_W      = 16;
  localparam int unsigned LOW_W       = 16;
  localparam int unsigned HIGH_W      = 10;
  localparam int unsigned WORD_W      = 26;
  localparam logic [7:0]  OFS_LOW     = 8'h00;
  localparam logic [7:0]  OFS_HIGH    = 8'h01;
  localparam int unsigned OE_BIT      = 10;
  localparam logic [15:0] RST_LOW     = 16'h0000;
  localparam logic [9:0]  RST_HIGH    = 10'h000;
  localparam logic        RST_OE      = 1'b0;
  localparam logic [15:0] ZERO_DATA   = 16'h0000;
  typedef logic [WORD_W-1:0] fpw_word_t;
  typedef enum logic [1:0] {
    FPW_IDLE,
    FPW_LOAD
  } fpw_state_e;
endpackage

// ===== core/fpw_apply_if.sv
// interface carrying the staged pull word from the register bank to the apply stage
`timescale 1ns/10ps
interface fpw_apply_if;
  logic                   load;   // one-cycle load request
  fpw_pkg::fpw_word_t     word;   // combined word to apply
  modport src (output load, output word);
  modport dst (input load, input word);
endinterface

// ===== core/fpw_apply_stage.sv
// output register that presents the applied pull word atomically
`timescale 1ns/10ps
module fpw_apply_stage (
  input  wire logic        mclk,    // system clock
  input  wire logic        rstn,    // synchronous reset, active low
  fpw_apply_if.dst         req,     // staged word and load strobe
  output fpw_pkg::fpw_word_t applied, // word seen by the pull stage
  output logic             updated  // one-cycle pulse after apply
);
  fpw_pkg::fpw_word_t applied_reg;
  logic               updated_reg;

  // capture the whole word in one edge
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      applied_reg <= {fpw_pkg::RST_HIGH, fpw_pkg::RST_LOW};
    end else if (req.load) begin
      applied_reg <= req.word;
    end
  end

  // pulse marking a fresh word on the pull stage
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      updated_reg <= 1'b0;
    end else begin
      updated_reg <= req.load;
    end
  end

  assign applied = applied_reg;
  assign updated = updated_reg;
endmodule

// ===== core/fpw_regs.sv
// register bank holding the pull setting word and software output enable
//
// Behaviour
// R1: low 16 bits in register 0x00
// R2: high 10 bits in register 0x01
// R3: all pull word bits reset to zero
// R4: combined word is signed two's complement
// R5: only high word write applies new setting
// R6: host writes low word before high word
// R7: bit 10 of 0x01 gates output driver
// R8: pin-controlled enable ignores software bit writes
// R9: bits 15 to 11 read zero, ignore writes
// R10: host limits updates to 38 kHz
// R11: low and high latched together atomically
`timescale 1ns/10ps
module fpw_regs (
  input  wire logic               mclk,         // system clock, 20 MHz
  input  wire logic               rstn,         // synchronous reset, low
  input  wire logic [7:0]         reg_addr,     // register address
  input  wire logic               reg_wr,       // write strobe, one cycle
  input  wire logic [15:0]        reg_wdata,    // write data
  input  wire logic               reg_rd,       // read strobe, one cycle
  output logic      [15:0]        reg_rdata,    // read data, registered
  input  wire logic               oe_pin_ctrl,  // 1: enable pin owns output
  input  wire logic               oe_pin,       // external enable pin level
  output logic                    out_enable,   // output driver enable
  output logic signed [25:0]      pull_setting_word, // applied signed word
  output logic                    pull_updated  // pulse on new word applied
);
  // ****************************************************************
  // register storage
  // ****************************************************************
  logic [15:0]        pull_word_low_half_reg;
  logic [9:0]         pull_word_high_half_reg;
  logic               sw_oe_reg;
  logic [15:0]        rdata_reg;
  fpw_pkg::fpw_word_t applied_word;
  fpw_pkg::fpw_state_e state_reg;
  fpw_apply_if        apply ();

  // address match helper
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  // low half, never touches the applied word by itself
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      pull_word_low_half_reg <= fpw_pkg::RST_LOW; // R3
    end else if (reg_wr && hit(reg_addr, fpw_pkg::OFS_LOW)) begin
      pull_word_low_half_reg <= reg_wdata; // R1
    end
  end

  // high half; upper bits of the write are dropped
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      pull_word_high_half_reg <= fpw_pkg::RST_HIGH; // R3
    end else if (reg_wr && hit(reg_addr, fpw_pkg::OFS_HIGH)) begin
      pull_word_high_half_reg <= reg_wdata[fpw_pkg::HIGH_W-1:0]; // R2 R9
    end
  end

  // software enable bit, frozen while the pin owns the driver
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      sw_oe_reg <= fpw_pkg::RST_OE; // R7
    end else if (reg_wr && hit(reg_addr, fpw_pkg::OFS_HIGH)
                 && !oe_pin_ctrl) begin
      sw_oe_reg <= reg_wdata[fpw_pkg::OE_BIT]; // R8
    end
  end

  // apply sequencer: a high write stages the load of both halves
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      state_reg <= fpw_pkg::FPW_IDLE;
    end else begin
      case (state_reg)
        fpw_pkg::FPW_IDLE: begin
          if (reg_wr && hit(reg_addr, fpw_pkg::OFS_HIGH)) begin
            state_reg <= fpw_pkg::FPW_LOAD; // R5
          end
        end
        fpw_pkg::FPW_LOAD: begin
          if (!(reg_wr && hit(reg_addr, fpw_pkg::OFS_HIGH))) begin
            state_reg <= fpw_pkg::FPW_IDLE;
          end
        end
        default: state_reg <= fpw_pkg::FPW_IDLE;
      endcase
    end
  end

  // both halves handed over as one word
  assign apply.load = (state_reg == fpw_pkg::FPW_LOAD); // R5
  assign apply.word = {pull_word_high_half_reg,
                       pull_word_low_half_reg}; // R11

  fpw_apply_stage u_apply (
    .mclk    (mclk),
    .rstn    (rstn),
    .req     (apply.dst),
    .applied (applied_word),
    .updated (pull_updated)
  );

  // read mux; unused bits and unmapped addresses read zero
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      rdata_reg <= fpw_pkg::ZERO_DATA;
    end else if (reg_rd) begin
      if (hit(reg_addr, fpw_pkg::OFS_LOW)) begin
        rdata_reg <= pull_word_low_half_reg;
      end else if (hit(reg_addr, fpw_pkg::OFS_HIGH)) begin
        rdata_reg <= {5'b0_0000, sw_oe_reg, pull_word_high_half_reg}; // R9
      end else begin
        rdata_reg <= fpw_pkg::ZERO_DATA;
      end
    end
  end

  assign reg_rdata         = rdata_reg;
  assign pull_setting_word = $signed(applied_word); // R4
  assign out_enable        = oe_pin_ctrl ? oe_pin : sw_oe_reg; // R7 R8

  // ****************************************************************
  // checks
  // ****************************************************************
  sequence s_high_wr;
    reg_wr && hit(reg_addr, fpw_pkg::OFS_HIGH);
  endsequence

  sequence s_low_only;
    reg_wr && hit(reg_addr, fpw_pkg::OFS_LOW);
  endsequence

  // read strobes aimed at each mapped register
  sequence s_low_rd;
    reg_rd && hit(reg_addr, fpw_pkg::OFS_LOW);
  endsequence

  sequence s_high_rd;
    reg_rd && hit(reg_addr, fpw_pkg::OFS_HIGH);
  endsequence

  // internal load followed by the update pulse on the pull stage
  sequence s_load_pulse;
    apply.load ##1 pull_updated;
  endsequence

  chk_low_no_apply: assert property (@(posedge mclk) disable iff (!rstn) // R5
    s_low_only |=> ##1 $stable(applied_word))
    else $error("low write changed applied word");

  chk_high_applies: assert property (@(posedge mclk) disable iff (!rstn) // R11
    s_high_wr |-> ##2 (applied_word == {$past(pull_word_high_half_reg, 1),
                                        $past(pull_word_low_half_reg, 1)}))
    else $error("high write did not apply combined word");

  chk_low_stored: assert property (@(posedge mclk) disable iff (!rstn) // R1
    s_low_only |=> (pull_word_low_half_reg == $past(reg_wdata)))
    else $error("low half not stored");

  chk_high_stored: assert property (@(posedge mclk) disable iff (!rstn) // R2
    s_high_wr |=> (pull_word_high_half_reg == $past(reg_wdata[9:0])))
    else $error("high half not stored");

  chk_reset_zero: assert property (@(posedge mclk) // R3
    !rstn |=> (pull_word_low_half_reg == 16'h0000
               && pull_word_high_half_reg == 10'h000 && !sw_oe_reg))
    else $error("fields not zero after reset");

  chk_pin_holds_oe: assert property (@(posedge mclk) disable iff (!rstn) // R8
    oe_pin_ctrl |=> $stable(sw_oe_reg))
    else $error("software enable changed under pin control");

  chk_sw_oe_drive: assert property (@(posedge mclk) disable iff (!rstn) // R7
    (s_high_wr and !oe_pin_ctrl) ##1 !oe_pin_ctrl
      |-> (out_enable == $past(reg_wdata[10])))
    else $error("output enable not following software bit");

  chk_unused_zero: assert property (@(posedge mclk) disable iff (!rstn) // R9
    reg_rd && hit(reg_addr, fpw_pkg::OFS_HIGH) |=> (reg_rdata[15:11] == 5'h00))
    else $error("unused bits read nonzero");

  chk_sign_kept: assert property (@(posedge mclk) disable iff (!rstn) // R4
    pull_updated |-> $past(apply.load)
      && ((pull_setting_word < 0)
          == $past(pull_word_high_half_reg[fpw_pkg::HIGH_W-1])))
    else $error("sign or update pulse mismatch");

  chk_high_load: assert property (@(posedge mclk) disable iff (!rstn) // R5
    s_high_wr |=> s_load_pulse)
    else $error("high write did not raise load and pulse");

  chk_low_no_load: assert property (@(posedge mclk) disable iff (!rstn) // R5
    s_low_only |=> !apply.load)
    else $error("low write raised a load");

  chk_word_held: assert property (@(posedge mclk) disable iff (!rstn) // R5
    !apply.load |=> $stable(applied_word))
    else $error("applied word moved without a load");

  chk_pulse_marks: assert property (@(posedge mclk) disable iff (!rstn) // R5
    !$stable(applied_word) |-> pull_updated)
    else $error("word changed without update pulse");

  chk_low_read: assert property (@(posedge mclk) disable iff (!rstn) // R1
    s_low_rd |=> (reg_rdata == $past(pull_word_low_half_reg)))
    else $error("low half read back wrong");

  chk_high_read: assert property (@(posedge mclk) disable iff (!rstn) // R2
    s_high_rd |=> (reg_rdata == {5'h00, $past(sw_oe_reg),
                                 $past(pull_word_high_half_reg)}))
    else $error("high half read back wrong");
endmodule

// ===== tb/fpw_host.sv
// host model driving the pull word register bus
`timescale 1ns/10ps
module fpw_host (
  input  wire logic        mclk,      // system clock
  output logic      [7:0]  reg_addr,  // register address
  output logic             reg_wr,    // write strobe
  output logic      [15:0] reg_wdata, // write data
  output logic             reg_rd,    // read strobe
  input  wire logic [15:0] reg_rdata  // read data
);
  // idle bus at time zero
  initial begin
    reg_addr  = 8'h00;
    reg_wr    = 1'b0;
    reg_wdata = 16'h0000;
    reg_rd    = 1'b0;
  end
  // one-cycle write, data scrambled once released
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr    <= 1'b0;
    reg_wdata <= ~d;
  endtask
  // one-cycle read, data taken once the answering edge has landed
  task automatic rd(input logic [7:0] a, output logic [15:0] q);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd   <= 1'b0;
    #1 q = reg_rdata;
  endtask
  // low half always goes first
  task automatic pair(input logic [15:0] l, input logic [15:0] h);
    wr(fpw_pkg::OFS_LOW, l);
    wr(fpw_pkg::OFS_HIGH, h);
  endtask
  // keep updates no faster than the allowed rate
  task automatic pause;
    repeat (527) @(posedge mclk);
  endtask
endmodule

// ===== tb/tb_top.sv
// self-checking bench for the pull word register bank
`timescale 1ns/10ps
module tb_top;
  logic               mclk = 1'b0;
  logic               rstn = 1'b0;
  logic               oe_pin_ctrl = 1'b0;
  logic               oe_pin = 1'b0;
  logic [7:0]         reg_addr;
  logic               reg_wr, reg_rd, out_enable, pull_updated, sw_oe, seen;
  logic [15:0]        reg_wdata, reg_rdata, q;
  logic signed [25:0] pull_setting_word;
  logic [25:0]        cur;
  logic [31:0]        rs;
  int                 err_total, checked;

  always #25 mclk = ~mclk;

  fpw_regs fpw_regs_i (.mclk, .rstn, .reg_addr, .reg_wr, .reg_wdata, .reg_rd,
    .reg_rdata, .oe_pin_ctrl, .oe_pin, .out_enable, .pull_setting_word,
    .pull_updated);
  fpw_host fpw_host_i (.mclk, .reg_addr, .reg_wr, .reg_wdata, .reg_rd,
    .reg_rdata);

  // xorshift source of stimulus
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic chk(input string n, input logic [25:0] s,
                     input logic [25:0] e);
    checked++;
    if (s !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic test_done;
    if (err_total == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // one update: low write, hold check, high write, pulse, word, readback
  task automatic step(input logic [15:0] l, input logic [15:0] h,
                      input logic pc, input logic pin);
    @(posedge mclk);
    oe_pin_ctrl <= pc;
    oe_pin      <= pin;
    fpw_host_i.wr(fpw_pkg::OFS_LOW, l);
    repeat (4) @(posedge mclk);
    #1 chk("held word", pull_setting_word, cur);
    fpw_host_i.pair(l, h);
    if (!pc)
      sw_oe = h[10];
    cur = {h[9:0], l};
    seen = 1'b0;
    for (int i = 0; i < 8 && !seen; i++) begin
      @(posedge mclk);
      #1 seen = pull_updated;
    end
    chk("update pulse", seen, 1'b1);
    if (!seen)
      test_done();
    chk("applied word", pull_setting_word, cur);
    chk("sign", pull_setting_word < 0, cur[25]);
    chk("out enable", out_enable, pc ? pin : sw_oe);
    fpw_host_i.rd(fpw_pkg::OFS_LOW, q);
    chk("low half", q, l);
    fpw_host_i.rd(fpw_pkg::OFS_HIGH, q);
    chk("high half", q, {5'h00, sw_oe, h[9:0]});
    fpw_host_i.pause();
  endtask
  // reset, corner words, unmapped access, then random updates
  initial begin
    err_total = 0;
    checked = 0;
    sw_oe = 1'b0;
    cur = 26'h00_0000;
    rs = 32'h0001_3315;
    repeat (8) @(posedge mclk);
    rstn <= 1'b1;
    fpw_host_i.rd(fpw_pkg::OFS_HIGH, q);
    chk("high reset", q, 26'h00_0000);
    fpw_host_i.rd(fpw_pkg::OFS_LOW, q);
    chk("low reset", q, 26'h00_0000);
    chk("word reset", pull_setting_word, 26'h00_0000);
    chk("enable reset", out_enable, 1'b0);
    step(16'h0000, 16'h0200, 1'b0, 1'b0);
    step(16'hFFFF, 16'hFFFF, 1'b0, 1'b1);
    step(16'hFFFF, 16'h01FF, 1'b1, 1'b0);
    fpw_host_i.wr(8'h02, 16'hFFFF);
    fpw_host_i.rd(8'h02, q);
    chk("unmapped", q, 26'h00_0000);
    for (int n = 0; n < 20; n++) begin
      rs = xs(rs);
      q = rs[15:0];
      rs = xs(rs);
      step(q, rs[31:16], rs[3], rs[7]);
    end
    // reset again after the random updates: every field back to zero
    @(posedge mclk);
    rstn <= 1'b0;
    repeat (2) @(posedge mclk);
    rstn <= 1'b1;
    #1 chk("word rerun", pull_setting_word, 26'h00_0000);
    chk("enable rerun", out_enable, oe_pin_ctrl & oe_pin);
    fpw_host_i.rd(fpw_pkg::OFS_HIGH, q);
    chk("high rerun", q, 26'h00_0000);
    fpw_host_i.rd(fpw_pkg::OFS_LOW, q);
    chk("low rerun", q, 26'h00_0000);
    test_done();
  end
endmodule
